// [rtl/crsf_pkg.sv]
// shared constants and types of the cpu register set and flags block
// How it works
// - carry flag, bit 0, set on carry out of or borrow into the top bit
// - parity flag, bit 2, set when low eight result bits hold even ones
// - aux carry flag, bit 4, set on carry or borrow across the low nibble
// - zero flag, bit 6, set for a zero result, cleared otherwise
// - sign flag, bit 7, copies the top bit of the result
// - overflow flag, bit 11, set when the signed result does not fit
// - single step flag, bit 8, traps after next instruction and clears itself
// - interrupt enable flag, bit 9, gates acceptance of maskable interrupts
// - direction flag, bit 10, makes string steps decrement, else increment
// - one 16-bit flags word, result bits and control bits 8 to 10
// - all state is held in flip-flops and kept while the clock stands still
// - no minimum clock rate, no timeout, any rate up to the maximum works
// - eight 16-bit general registers, each writable as two byte halves
// - four 16-bit segment registers
// - a 16-bit instruction pointer holds the next instruction offset
package crsf_pkg;

  // flag bit positions
  localparam int CARRY_POS  = 0;
  localparam int PARITY_POS = 2;
  localparam int AUX_POS    = 4;
  localparam int ZERO_POS   = 6;
  localparam int SIGN_POS   = 7;
  localparam int STEP_POS   = 8;
  localparam int IE_POS     = 9;
  localparam int DIR_POS    = 10;
  localparam int OVF_POS    = 11;

  // writable flag bits and reset values
  localparam logic [15:0] FLAGS_WMASK = 16'h0FD5;
  localparam logic [15:0] FLAGS_RST   = 16'h0000;
  localparam logic [15:0] WORD_RST    = 16'h0000;

  // register indices, byte address is four times the index
  localparam logic [4:0] IDX_FLAGS  = 5'h00;
  localparam logic [4:0] IDX_CMD    = 5'h01;
  localparam logic [4:0] IDX_OPA    = 5'h02;
  localparam logic [4:0] IDX_OPB    = 5'h03;
  localparam logic [4:0] IDX_RESULT = 5'h04;
  localparam logic [4:0] IDX_IP     = 5'h05;
  localparam logic [4:0] IDX_STEP   = 5'h06;
  localparam logic [4:0] IDX_INTREQ = 5'h07;
  localparam logic [4:0] IDX_VECTOR = 5'h08;
  localparam logic [4:0] IDX_ISTAT  = 5'h09;
  localparam logic [4:0] IDX_IMASK  = 5'h0A;
  localparam logic [4:0] IDX_GPR0   = 5'h10;
  localparam logic [4:0] IDX_SEG0   = 5'h18;
  localparam logic [4:0] IDX_LAST   = 5'h1B;

  // command and step register fields
  localparam int CMD_WORD_POS = 3;
  localparam int STR_POS      = 4;
  localparam int STRW_POS     = 5;
  localparam int SRC_IDX      = 6;
  localparam int DST_IDX      = 7;

  // interrupt status bits
  localparam int EV_STEP   = 0;
  localparam int EV_ACCEPT = 1;
  localparam int EV_REFUSE = 2;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // alu operations
  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_ADC = 3'b001,
    OP_SUB = 3'b010,
    OP_SBB = 3'b011,
    OP_AND = 3'b100,
    OP_OR  = 3'b101,
    OP_XOR = 3'b110,
    OP_INC = 3'b111
  } crsf_op_type;

  // result characteristics from the alu
  typedef struct packed {
    logic overflow;
    logic sign;
    logic zero;
    logic aux;
    logic parity;
    logic carry;
  } crsf_alu_flags_type;

endpackage

// [rtl/crsf_alu.sv]
// byte and word alu with result flag generation
`timescale 1ns/100ps
`default_nettype none
module crsf_alu (
  input  wire logic                        isWord,
  input  wire logic                        carryIn,
  input  wire crsf_pkg::crsf_op_type       op,
  input  wire logic [15:0]                 opA,
  input  wire logic [15:0]                 opB,
  output logic [15:0]                      result,
  output var crsf_pkg::crsf_alu_flags_type flags
);
  logic [16:0] a17;
  logic [16:0] b17;
  logic [16:0] raw;
  logic        isSub;
  logic        isLogic;
  logic        msbA;
  logic        msbB;
  logic        msbR;
  logic        carryOut;

  // operands are masked to the width, the extra bit catches carry or borrow
  always_comb begin
    a17 = {1'b0, isWord ? opA : {8'h00, opA[7:0]}};
    b17 = {1'b0, isWord ? opB : {8'h00, opB[7:0]}};
    if (op == crsf_pkg::OP_INC) begin
      b17 = 17'h0_0001;
    end
    unique case (op)
      crsf_pkg::OP_ADD: raw = a17 + b17;
      crsf_pkg::OP_ADC: raw = a17 + b17 + {16'h0000, carryIn};
      crsf_pkg::OP_SUB: raw = a17 - b17;
      crsf_pkg::OP_SBB: raw = a17 - b17 - {16'h0000, carryIn};
      crsf_pkg::OP_AND: raw = a17 & b17;
      crsf_pkg::OP_OR:  raw = a17 | b17;
      crsf_pkg::OP_XOR: raw = a17 ^ b17;
      crsf_pkg::OP_INC: raw = a17 + b17;
    endcase
  end

  // width selects which bit counts as the top bit
  always_comb begin
    isSub    = (op == crsf_pkg::OP_SUB) || (op == crsf_pkg::OP_SBB);
    isLogic  = op[2] && (op != crsf_pkg::OP_INC);
    result   = isWord ? raw[15:0] : {8'h00, raw[7:0]};
    carryOut = isWord ? raw[16] : raw[8];
    msbA     = isWord ? a17[15] : a17[7];
    msbB     = isWord ? b17[15] : b17[7];
    msbR     = isWord ? raw[15] : raw[7];
  end

  // result flags, logic operations clear carry, aux and overflow
  always_comb begin
    flags.carry    = !isLogic && carryOut;
    flags.parity   = ~^result[7:0];
    flags.aux      = !isLogic && (a17[4] ^ b17[4] ^ raw[4]);
    flags.zero     = (result == 16'h0000);
    flags.sign     = msbR;
    flags.overflow = !isLogic && (msbR != msbA) &&
                     (isSub ? (msbA != msbB) : (msbA == msbB));
  end
endmodule
`default_nettype wire

// [rtl/crsf_core.sv]
// register set, flags word and axi4-lite slave of the cpu core
`timescale 1ns/100ps
`default_nettype none
module crsf_core #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   irq
);
  // the map needs index 27, so seven address bits at least
  if (ADDR_W < 7) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  logic [ADDR_W-1:0]            awAddrQ;
  logic                         awHeld;
  logic [31:0]                  wDataQ;
  logic [3:0]                   wStrbQ;
  logic                         wHeld;
  logic                         wrEn;
  logic                         wrGo;
  logic [4:0]                   wrIdx;
  logic [15:0]                  flags;
  logic [15:0]                  gpr [8];
  logic [15:0]                  seg [4];
  logic [15:0]                  ip;
  logic [15:0]                  opA;
  logic [15:0]                  opB;
  logic [15:0]                  result;
  logic [15:0]                  vector;
  logic [3:0]                   cmdQ;
  logic [2:0]                   istat;
  logic [2:0]                   imask;
  logic [2:0]                   evSet;
  logic [2:0]                   evClr;
  logic                         selCmd;
  logic                         selStep;
  logic                         selInt;
  logic [15:0]                  strDelta;
  logic [15:0]                  aluResult;
  crsf_pkg::crsf_alu_flags_type aluFlags;
  crsf_pkg::crsf_op_type        aluOp;

  // index of an address, out-of-range high bits give an unmapped index
  function automatic logic [4:0] regIdx(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] hi;
    hi = addr >> 7;
    regIdx = (hi == '0) ? addr[6:2] : 5'h1F;
  endfunction

  function automatic logic isMapped(input logic [4:0] idx);
    isMapped = (idx <= crsf_pkg::IDX_IMASK) ||
               (idx >= crsf_pkg::IDX_GPR0 && idx <= crsf_pkg::IDX_LAST);
  endfunction

  // byte lanes 0 and 1 write the low and high halves independently
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // read value of one register, reserved bits read as zero
  function automatic logic [31:0] readReg(input logic [4:0] idx);
    readReg = 32'h0000_0000;
    if (idx >= crsf_pkg::IDX_GPR0 && idx < crsf_pkg::IDX_SEG0) begin
      readReg[15:0] = gpr[idx[2:0]];
    end else if (idx >= crsf_pkg::IDX_SEG0 && idx <= crsf_pkg::IDX_LAST) begin
      readReg[15:0] = seg[idx[1:0]];
    end else begin
      unique case (idx)
        crsf_pkg::IDX_FLAGS:  readReg[15:0] = flags;
        crsf_pkg::IDX_CMD:    readReg[3:0]  = cmdQ;
        crsf_pkg::IDX_OPA:    readReg[15:0] = opA;
        crsf_pkg::IDX_OPB:    readReg[15:0] = opB;
        crsf_pkg::IDX_RESULT: readReg[15:0] = result;
        crsf_pkg::IDX_IP:     readReg[15:0] = ip;
        crsf_pkg::IDX_VECTOR: readReg[15:0] = vector;
        crsf_pkg::IDX_ISTAT:  readReg[2:0]  = istat;
        crsf_pkg::IDX_IMASK:  readReg[2:0]  = imask;
        default:              readReg = 32'h0000_0000;
      endcase
    end
  endfunction

  // write address channel, one address held until its write is done
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld  <= 1'b0;
      awready <= 1'b0;
      awAddrQ <= '0;
    end else if (awvalid && awready) begin
      awHeld  <= 1'b1;
      awready <= 1'b0;
      awAddrQ <= awaddr;
    end else if (wrEn) begin
      awHeld  <= 1'b0;
    end else if (!awHeld) begin
      awready <= 1'b1;
    end
  end

  // write data channel, taken independently of the address
  always_ff @(posedge clk) begin
    if (rst) begin
      wHeld  <= 1'b0;
      wready <= 1'b0;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end else if (wvalid && wready) begin
      wHeld  <= 1'b1;
      wready <= 1'b0;
      wDataQ <= wdata;
      wStrbQ <= wstrb;
    end else if (wrEn) begin
      wHeld  <= 1'b0;
    end else if (!wHeld) begin
      wready <= 1'b1;
    end
  end

  // write commits once both halves are in and no response is pending
  assign wrEn    = awHeld && wHeld && !bvalid;
  assign wrIdx   = regIdx(awAddrQ);
  assign wrGo    = wrEn && isMapped(wrIdx);
  assign selCmd  = wrGo && (wrIdx == crsf_pkg::IDX_CMD);
  assign selStep = wrGo && (wrIdx == crsf_pkg::IDX_STEP);
  assign selInt  = wrGo && (wrIdx == crsf_pkg::IDX_INTREQ) && wDataQ[0];

  // write response, unmapped addresses answer slverr
  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp  <= crsf_pkg::RESP_OKAY;
    end else if (wrEn) begin
      bvalid <= 1'b1;
      bresp  <= isMapped(wrIdx) ? crsf_pkg::RESP_OKAY : crsf_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel, data registered one cycle after the address
  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= crsf_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= readReg(regIdx(araddr));
      rresp   <= isMapped(regIdx(araddr)) ? crsf_pkg::RESP_OKAY : crsf_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // the alu works on the operand registers and the current carry
  assign aluOp = crsf_pkg::crsf_op_type'(wDataQ[2:0]);

  crsf_alu u_alu (
    .isWord  (wDataQ[crsf_pkg::CMD_WORD_POS]),
    .carryIn (flags[crsf_pkg::CARRY_POS]),
    .op      (aluOp),
    .opA     (opA),
    .opB     (opB),
    .result  (aluResult),
    .flags   (aluFlags)
  );

  // operands, last command and result
  always_ff @(posedge clk) begin
    if (rst) begin
      opA    <= crsf_pkg::WORD_RST;
      opB    <= crsf_pkg::WORD_RST;
      result <= crsf_pkg::WORD_RST;
      vector <= crsf_pkg::WORD_RST;
      cmdQ   <= 4'h0;
    end else if (wrGo) begin
      if (wrIdx == crsf_pkg::IDX_OPA) begin
        opA <= merge16(opA, wDataQ, wStrbQ);
      end
      if (wrIdx == crsf_pkg::IDX_OPB) begin
        opB <= merge16(opB, wDataQ, wStrbQ);
      end
      if (wrIdx == crsf_pkg::IDX_VECTOR) begin
        vector <= merge16(vector, wDataQ, wStrbQ);
      end
      if (selCmd) begin
        result <= aluResult;
        cmdQ   <= wDataQ[3:0];
      end
    end
  end

  // flags word: software write, alu result or single-step trap
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= crsf_pkg::FLAGS_RST;
    end else if (wrGo && wrIdx == crsf_pkg::IDX_FLAGS) begin
      flags <= merge16(flags, wDataQ, wStrbQ) & crsf_pkg::FLAGS_WMASK;
    end else if (selCmd) begin
      flags[crsf_pkg::CARRY_POS]  <= aluFlags.carry;
      flags[crsf_pkg::PARITY_POS] <= aluFlags.parity;
      flags[crsf_pkg::AUX_POS]    <= aluFlags.aux;
      flags[crsf_pkg::ZERO_POS]   <= aluFlags.zero;
      flags[crsf_pkg::SIGN_POS]   <= aluFlags.sign;
      flags[crsf_pkg::OVF_POS]    <= aluFlags.overflow;
    end else if (selStep && flags[crsf_pkg::STEP_POS]) begin
      flags[crsf_pkg::STEP_POS]   <= 1'b0;
    end
  end

  // string step size follows the width bit, its sign the direction flag
  always_comb begin
    strDelta = wDataQ[crsf_pkg::STRW_POS] ? 16'h0002 : 16'h0001;
    if (flags[crsf_pkg::DIR_POS]) begin
      strDelta = ~strDelta + 16'h0001;
    end
  end

  // general registers, halves through byte strobes, string index stepping
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        gpr[i] <= crsf_pkg::WORD_RST;
      end
    end else if (wrGo && wrIdx >= crsf_pkg::IDX_GPR0 && wrIdx < crsf_pkg::IDX_SEG0) begin
      gpr[wrIdx[2:0]] <= merge16(gpr[wrIdx[2:0]], wDataQ, wStrbQ);
    end else if (selStep && wDataQ[crsf_pkg::STR_POS]) begin
      gpr[crsf_pkg::SRC_IDX] <= gpr[crsf_pkg::SRC_IDX] + strDelta;
      gpr[crsf_pkg::DST_IDX] <= gpr[crsf_pkg::DST_IDX] + strDelta;
    end
  end

  // segment registers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        seg[i] <= crsf_pkg::WORD_RST;
      end
    end else if (wrGo && wrIdx >= crsf_pkg::IDX_SEG0) begin
      seg[wrIdx[1:0]] <= merge16(seg[wrIdx[1:0]], wDataQ, wStrbQ);
    end
  end

  // instruction pointer: load, advance by instruction length, or vector
  always_ff @(posedge clk) begin
    if (rst) begin
      ip <= crsf_pkg::WORD_RST;
    end else if (wrGo && wrIdx == crsf_pkg::IDX_IP) begin
      ip <= merge16(ip, wDataQ, wStrbQ);
    end else if (selStep) begin
      ip <= ip + {12'h000, wDataQ[3:0]};
    end else if (selInt && flags[crsf_pkg::IE_POS]) begin
      ip <= vector;
    end
  end

  // events set sticky status, set wins over a write-one clear
  always_comb begin
    evSet = 3'b000;
    evSet[crsf_pkg::EV_STEP]   = selStep && flags[crsf_pkg::STEP_POS];
    evSet[crsf_pkg::EV_ACCEPT] = selInt && flags[crsf_pkg::IE_POS];
    evSet[crsf_pkg::EV_REFUSE] = selInt && !flags[crsf_pkg::IE_POS];
    evClr = (wrGo && wrIdx == crsf_pkg::IDX_ISTAT) ? wDataQ[2:0] : 3'b000;
  end

  // status, mask and the level interrupt line
  always_ff @(posedge clk) begin
    if (rst) begin
      istat <= 3'b000;
      imask <= 3'b000;
      irq   <= 1'b0;
    end else begin
      istat <= (istat & ~evClr) | evSet;
      irq   <= |(istat & imask);
      if (wrGo && wrIdx == crsf_pkg::IDX_IMASK) begin
        imask <= wDataQ[2:0];
      end
    end
  end

  // all state is plain flip-flops with no refresh and no timer, so the
  // clock may stop anywhere and run at any rate

  logic [16:0] addChk;
  assign addChk = {1'b0, opA} + {1'b0, opB};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  carry_word_add_a: assert property (
    selCmd && aluOp == crsf_pkg::OP_ADD && wDataQ[crsf_pkg::CMD_WORD_POS]
    |=> flags[crsf_pkg::CARRY_POS] == $past(addChk[16]))
    else $error("carry flag wrong after word add");
  parity_flag_a: assert property (
    selCmd |=> flags[crsf_pkg::PARITY_POS] == ~^result[7:0])
    else $error("parity flag does not match result");
  aux_carry_a: assert property (
    selCmd && aluOp == crsf_pkg::OP_ADD
    |=> flags[crsf_pkg::AUX_POS] == ($past(opA[4]) ^ $past(opB[4]) ^ result[4]))
    else $error("aux carry flag wrong after add");
  zero_flag_a: assert property (
    selCmd |=> flags[crsf_pkg::ZERO_POS] == (result == 16'h0000))
    else $error("zero flag does not match result");
  sign_width_a: assert property (
    selCmd |=> flags[crsf_pkg::SIGN_POS] ==
      ($past(wDataQ[crsf_pkg::CMD_WORD_POS]) ? result[15] : result[7]))
    else $error("sign flag taken from wrong bit");
  overflow_add_a: assert property (
    selCmd && aluOp == crsf_pkg::OP_ADD && wDataQ[crsf_pkg::CMD_WORD_POS]
    |=> flags[crsf_pkg::OVF_POS] ==
      ($past(opA[15]) == $past(opB[15]) && result[15] != $past(opA[15])))
    else $error("overflow flag wrong after word add");
  single_step_a: assert property (
    selStep && flags[crsf_pkg::STEP_POS]
    |=> !flags[crsf_pkg::STEP_POS] && istat[crsf_pkg::EV_STEP] ##1 (irq || !$past(imask[0])))
    else $error("single step trap not taken");
  int_accept_a: assert property (
    selInt && flags[crsf_pkg::IE_POS]
    |=> ip == $past(vector) && istat[crsf_pkg::EV_ACCEPT])
    else $error("enabled interrupt not accepted");
  int_refuse_a: assert property (
    selInt && !flags[crsf_pkg::IE_POS] && !selStep
    |=> $stable(ip) && istat[crsf_pkg::EV_REFUSE])
    else $error("interrupt accepted while disabled");
  string_dir_a: assert property (
    selStep && wDataQ[crsf_pkg::STR_POS] && !wDataQ[crsf_pkg::STRW_POS]
    |=> gpr[crsf_pkg::DST_IDX] == ($past(flags[crsf_pkg::DIR_POS]) ?
      $past(gpr[crsf_pkg::DST_IDX]) - 16'h0001 : $past(gpr[crsf_pkg::DST_IDX]) + 16'h0001))
    else $error("string index stepped the wrong way");
  state_hold_a: assert property (
    !wrEn [*2] |-> $stable(ip) && $stable(flags) && $stable(gpr[0]))
    else $error("state changed without a write");
  resp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  alu_cmd_c:   cover property (selCmd ##1 flags[crsf_pkg::OVF_POS]);
  step_trap_c: cover property (evSet[crsf_pkg::EV_STEP] ##2 irq);
  int_take_c:  cover property (evSet[crsf_pkg::EV_ACCEPT]);
  int_deny_c:  cover property (evSet[crsf_pkg::EV_REFUSE]);
endmodule
`default_nettype wire

// [sim/tb.sv]
// self-checking bench of the register set and flags block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        run = 1'b1;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        slowB = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          errTotal = 0;
  int          comparisons = 0;
  // one alu case: command, operands, flags before, result and flags after
  typedef struct packed {
    logic [15:0] cmd, opA, opB, fIn, res, fOut;
  } crsf_tb_row_type;
  crsf_tb_row_type rows [10] = '{
    '{16'h0000, 16'h007F, 16'h0001, 16'h0000, 16'h0080, 16'h0890},
    '{16'h0008, 16'hFFFF, 16'h0001, 16'h0000, 16'h0000, 16'h0055},
    '{16'h0001, 16'h0010, 16'h000F, 16'h0001, 16'h0020, 16'h0010},
    '{16'h0002, 16'h0000, 16'h0001, 16'h0000, 16'h00FF, 16'h0095},
    '{16'h000B, 16'h8000, 16'h0000, 16'h0001, 16'h7FFF, 16'h0814},
    '{16'h000C, 16'hF0F0, 16'h0FF0, 16'h0700, 16'h00F0, 16'h0704},
    '{16'h0005, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0044},
    '{16'h0006, 16'h12A5, 16'h005A, 16'h0000, 16'h00FF, 16'h0084},
    '{16'h000F, 16'h7FFF, 16'h0000, 16'h0000, 16'h8000, 16'h0894},
    '{16'h0007, 16'h00FF, 16'h0000, 16'h0000, 16'h0000, 16'h0055}};

  // clock that can be frozen in either phase
  always #10 clk = run ? ~clk : clk;

  crsf_core #(.ADDR_W(8)) crsf_core_i (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq));

  task automatic give_verdict;
    if (errTotal == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // bus write; addresses above bit 6 must answer with an error code
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    logic       ta, tw, tk, hb;
    logic [1:0] r;
    int         n;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= !slowB;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tk = bvalid & bready;
      hb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) break;
      if (hb) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (n == 40) errTotal++;
    if (n == 40) give_verdict;
    chk(32'(r), a[7] ? 32'h0000_0002 : 32'h0000_0000);
  endtask

  // bus read compared with an expected word and response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic        ta, tk;
    logic [1:0]  r;
    logic [31:0] v;
    int          n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = arvalid & arready;
      tk = rvalid;
      v = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tk) break;
    end
    rready <= 1'b0;
    if (n == 40) errTotal++;
    if (n == 40) give_verdict;
    chk(v, exp);
    chk(32'(r), a[7] ? 32'h0000_0002 : 32'h0000_0000);
  endtask

  // interrupt line looked at mid-cycle
  task automatic ci(input logic e);
    @(negedge clk);
    chk(32'(irq), 32'(e));
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // alu cases from the table
    foreach (rows[i]) begin
      wr(8'h00, rows[i].fIn, 4'h3);
      wr(8'h08, rows[i].opA, 4'h3);
      wr(8'h0C, rows[i].opB, 4'h3);
      wr(8'h04, rows[i].cmd, 4'h3);
      rd(8'h10, {16'h0000, rows[i].res});
      rd(8'h04, 32'(rows[i].cmd[3:0]));
      rd(8'h00, {16'h0000, rows[i].fOut});
    end
    // flags word, byte halves, register file, clock frozen high
    wr(8'h00, 16'hFFFF, 4'h3);
    rd(8'h00, 32'h0000_0FD5);
    wr(8'h40, 16'h1234, 4'h3);
    wr(8'h40, 16'hABCD, 4'h2);
    rd(8'h40, 32'h0000_AB34);
    for (int i = 0; i < 11; i++) wr(8'h44 + 8'(4 * i), 16'hA000 + 16'(i), 4'h3);
    #5 run = 1'b0;
    #4000 run = 1'b1;
    for (int i = 0; i < 11; i++) rd(8'h44 + 8'(4 * i), 32'h0000_A000 + 32'(i));
    // clock frozen low this time, then a late write response
    #15 run = 1'b0;
    #4000 run = 1'b1;
    rd(8'h44, 32'h0000_A000);
    slowB = 1'b1;
    wr(8'h20, 16'h0123, 4'h3);
    slowB = 1'b0;
    rd(8'h20, 32'h0000_0123);
    wr(8'h10, 16'h5555, 4'h3);
    rd(8'h10, 32'h0000_0000);
    wr(8'h80, 16'h1234, 4'h3);
    rd(8'h80, 32'h0000_0000);
    // single-step trap, then no trap once the flag is clear
    wr(8'h28, 16'h0007, 4'h3);
    wr(8'h14, 16'h0100, 4'h3);
    wr(8'h00, 16'h0100, 4'h3);
    wr(8'h18, 16'h0003, 4'h3);
    rd(8'h14, 32'h0000_0103);
    rd(8'h00, 32'h0000_0000);
    rd(8'h24, 32'h0000_0001);
    ci(1'b1);
    wr(8'h24, 16'h0001, 4'h3);
    ci(1'b0);
    wr(8'h18, 16'h0000, 4'h3);
    rd(8'h24, 32'h0000_0000);
    // string index steps down then up, by two then one
    wr(8'h58, 16'h0010, 4'h3);
    wr(8'h5C, 16'h0020, 4'h3);
    wr(8'h00, 16'h0400, 4'h3);
    wr(8'h18, 16'h0030, 4'h3);
    rd(8'h58, 32'h0000_000E);
    rd(8'h5C, 32'h0000_001E);
    wr(8'h00, 16'h0000, 4'h3);
    wr(8'h18, 16'h0010, 4'h3);
    rd(8'h58, 32'h0000_000F);
    rd(8'h5C, 32'h0000_001F);
    // maskable request accepted when enabled, refused when not
    wr(8'h20, 16'h0500, 4'h3);
    wr(8'h00, 16'h0200, 4'h3);
    wr(8'h1C, 16'h0001, 4'h3);
    rd(8'h14, 32'h0000_0500);
    rd(8'h00, 32'h0000_0200);
    wr(8'h00, 16'h0000, 4'h3);
    wr(8'h14, 16'h0600, 4'h3);
    wr(8'h1C, 16'h0001, 4'h3);
    rd(8'h14, 32'h0000_0600);
    rd(8'h24, 32'h0000_0006);
    ci(1'b1);
    wr(8'h28, 16'h0001, 4'h3);
    ci(1'b0);
    wr(8'h28, 16'h0007, 4'h3);
    ci(1'b1);
    wr(8'h24, 16'h0006, 4'h3);
    ci(1'b0);
    // second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h00, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h44, 32'h0000_0000);
    rd(8'h28, 32'h0000_0000);
    give_verdict;
  end
endmodule
`default_nettype wire
